// ---- rtl/core_exec_pkg.sv ----
package core_exec_pkg;

  // Datapath widths.
  localparam int DATA_W  = 8;
  localparam int PC_W    = 10;
  localparam int FADDR_W = 5;
  localparam int OP_W    = 3;
  localparam int RADDR_W = 4;
  localparam int RDATA_W = 32;
  localparam int EVT_W   = 3;

  // Operation codes on the instruction port.
  localparam logic [OP_W-1:0] NOP_OP           = 3'h0;
  localparam logic [OP_W-1:0] CONFIG_LOAD_OP   = 3'h1;
  localparam logic [OP_W-1:0] LOAD_LITERAL_OP  = 3'h2;
  localparam logic [OP_W-1:0] RETURN_LITERAL_OP = 3'h3;
  localparam logic [OP_W-1:0] SLEEP_OP         = 3'h4;
  localparam logic [OP_W-1:0] ROTATE_LEFT_OP   = 3'h5;
  localparam logic [OP_W-1:0] SUBTRACT_OP      = 3'h6;

  // Destination select.
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Register offsets.
  localparam logic [RADDR_W-1:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [RADDR_W-1:0] REG_IRQ_CLEAR  = 4'h4;
  localparam logic [RADDR_W-1:0] REG_IRQ_ENABLE = 4'h8;
  localparam logic [RADDR_W-1:0] REG_CORE_STATE = 4'hc;

  // Event bit positions.
  localparam int EVT_SLEEP  = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_BORROW = 2;

  // Core state readback field positions.
  localparam int ST_ACC_LSB   = 0;
  localparam int ST_CARRY     = 8;
  localparam int ST_DCARRY    = 9;
  localparam int ST_ZERO      = 10;
  localparam int ST_TIMEOUT   = 11;
  localparam int ST_POWERDOWN = 12;
  localparam int ST_SLEEPING  = 13;
  localparam int ST_FLUSHING  = 14;

  // Reset values and constants.
  localparam logic [DATA_W-1:0] ACC_RST       = 8'h00;
  localparam logic [DATA_W-1:0] CONFIG_RST    = 8'hff;
  localparam logic [PC_W-1:0]   PC_RST        = 10'h000;
  localparam logic [PC_W-1:0]   PC_STEP       = 10'h001;
  localparam logic              TIMEOUT_RST   = 1'b1;
  localparam logic              POWERDOWN_RST = 1'b1;
  localparam logic [EVT_W-1:0]  IRQ_EN_RST    = 3'h0;

  typedef enum logic [1:0] {PH_RUN, PH_FLUSH, PH_SLEEP} phase_e;

endpackage

// ---- rtl/alu_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  logic [core_exec_pkg::DATA_W-1:0] f;
  logic [core_exec_pkg::DATA_W-1:0] w;
  logic                             carry_in;
  logic [core_exec_pkg::OP_W-1:0]   op;
  logic [core_exec_pkg::DATA_W-1:0] result;
  logic                             carry_out;
  logic                             dc_out;
  logic                             zero_out;

  modport core (output f, w, carry_in, op,
                input  result, carry_out, dc_out, zero_out);
  modport alu  (input  f, w, carry_in, op,
                output result, carry_out, dc_out, zero_out);
endinterface
`default_nettype wire

// ---- rtl/exec_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_alu (
  // Operands and results.
  alu_if.alu bus
);

  always_comb begin
    logic [8:0] full;
    logic [4:0] low;
    full = 9'h000;
    low  = 5'h00;
    bus.result    = bus.f;
    bus.carry_out = bus.carry_in;
    bus.dc_out    = 1'b0;
    unique case (bus.op)
      core_exec_pkg::ROTATE_LEFT_OP: begin
        bus.result    = {bus.f[6:0], bus.carry_in};
        bus.carry_out = bus.f[7];
      end
      core_exec_pkg::SUBTRACT_OP: begin
        // Adding the inverted operand plus one leaves carry high on no borrow.
        full = {1'b0, bus.f} + {1'b0, ~bus.w} + 9'h001;
        low  = {1'b0, bus.f[3:0]} + {1'b0, ~bus.w[3:0]} + 5'h01;
        bus.result    = full[7:0];
        bus.carry_out = full[8];
        bus.dc_out    = low[4];
      end
      default: begin
        bus.result = bus.f;
      end
    endcase
    bus.zero_out = (bus.result == 8'h00);
  end

endmodule
`default_nettype wire

// ---- rtl/irq_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_unit (
  // Clock and reset.
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  // Events and software access.
  input  wire logic [core_exec_pkg::EVT_W-1:0] i_event,
  input  wire logic                            i_clear_we,
  input  wire logic                            i_enable_we,
  input  wire logic [core_exec_pkg::EVT_W-1:0] i_wdata,
  // State.
  output logic      [core_exec_pkg::EVT_W-1:0] o_status,
  output logic      [core_exec_pkg::EVT_W-1:0] o_enable,
  output logic                                 o_irq
);

  typedef struct packed {
    logic [core_exec_pkg::EVT_W-1:0] status;
    logic [core_exec_pkg::EVT_W-1:0] enable;
    logic                            irq;
  } irq_s;

  irq_s irq_reg;
  irq_s irq_next;

  always_comb begin
    irq_next = irq_reg;
    // A new event wins over a clear in the same cycle.
    if (i_clear_we) begin
      irq_next.status = irq_reg.status & ~i_wdata;
    end
    irq_next.status = irq_next.status | i_event;
    if (i_enable_we) begin
      irq_next.enable = i_wdata;
    end
    irq_next.irq = |(irq_next.status & irq_next.enable);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_reg <= '{status: '0, enable: core_exec_pkg::IRQ_EN_RST, irq: 1'b0};
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign o_status = irq_reg.status;
  assign o_enable = irq_reg.enable;
  assign o_irq    = irq_reg.irq;

endmodule
`default_nettype wire

// ---- rtl/cpu_instruction_subset_exec.sv ----
// Functional notes
// - Config-load copies accumulator into prescaler config; flags untouched.
// - Literal-load puts the 8-bit literal into accumulator; flags untouched.
// - Return loads literal into accumulator, program counter from stack top.
// - Return takes two cycles; the following fetched instruction is dropped.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep sets timeout flag, clears powerdown flag, leaves wake flag.
// - After sleep no instruction executes until wake-up.
// - Rotate-left goes through carry; only carry changes among flags.
// - Subtract computes file minus accumulator; updates carry, digit carry, zero.
// - Destination bit 0 writes accumulator, 1 writes the file register.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_subset_exec (
  // Clock and reset.
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  // Instruction port.
  input  wire logic                                i_instr_valid,
  input  wire logic [core_exec_pkg::OP_W-1:0]      i_instr_op,
  input  wire logic [core_exec_pkg::FADDR_W-1:0]   i_instr_file_addr,
  input  wire logic                                i_instr_dest,
  input  wire logic [core_exec_pkg::DATA_W-1:0]    i_instr_literal,
  output logic                                     o_ready,
  // File register port.
  input  wire logic [core_exec_pkg::DATA_W-1:0]    i_file_rdata,
  output logic                                     o_file_we,
  output logic      [core_exec_pkg::FADDR_W-1:0]   o_file_addr,
  output logic      [core_exec_pkg::DATA_W-1:0]    o_file_wdata,
  // Program flow.
  input  wire logic [core_exec_pkg::PC_W-1:0]      i_stack_top,
  output logic                                     o_stack_pop,
  output logic      [core_exec_pkg::PC_W-1:0]      o_program_counter,
  // Watchdog, prescaler and sleep.
  output logic      [core_exec_pkg::DATA_W-1:0]    o_prescaler_config,
  output logic                                     o_watchdog_clear,
  output logic                                     o_sleep,
  input  wire logic                                i_wake,
  // Accumulator and flags.
  output logic      [core_exec_pkg::DATA_W-1:0]    o_accumulator,
  output logic                                     o_carry_flag,
  output logic                                     o_digit_carry_flag,
  output logic                                     o_zero_flag,
  output logic                                     o_timeout_flag,
  output logic                                     o_powerdown_flag,
  // Register port.
  input  wire logic [core_exec_pkg::RADDR_W-1:0]   i_reg_addr,
  input  wire logic [core_exec_pkg::RDATA_W-1:0]   i_reg_wdata,
  input  wire logic                                i_reg_we,
  input  wire logic                                i_reg_re,
  output logic      [core_exec_pkg::RDATA_W-1:0]   o_reg_rdata,
  // Interrupt.
  output logic                                     o_irq
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    core_exec_pkg::phase_e                  phase;
    logic [core_exec_pkg::DATA_W-1:0]       acc;
    logic [core_exec_pkg::DATA_W-1:0]       cfg;
    logic [core_exec_pkg::PC_W-1:0]         pc;
    logic                                   c;
    logic                                   dc;
    logic                                   z;
    logic                                   to;
    logic                                   pd;
    logic                                   file_we;
    logic [core_exec_pkg::FADDR_W-1:0]      file_addr;
    logic [core_exec_pkg::DATA_W-1:0]       file_wdata;
    logic                                   stack_pop;
    logic                                   wdt_clear;
    logic                                   ready;
    logic                                   sleep;
    logic [core_exec_pkg::RDATA_W-1:0]      rdata;
  } core_s;

  core_s                              core_reg;
  core_s                              core_next;
  logic                               accept;
  logic [core_exec_pkg::EVT_W-1:0]    events;
  logic [core_exec_pkg::EVT_W-1:0]    irq_status;
  logic [core_exec_pkg::EVT_W-1:0]    irq_enable;
  logic                               irq_level;
  logic                               clear_we;
  logic                               enable_we;
  logic [core_exec_pkg::RDATA_W-1:0]  state_word;

  alu_if alu ();

  exec_alu u_alu (
    .bus (alu.alu)
  );

  irq_unit u_irq (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_event     (events),
    .i_clear_we  (clear_we),
    .i_enable_we (enable_we),
    .i_wdata     (i_reg_wdata[core_exec_pkg::EVT_W-1:0]),
    .o_status    (irq_status),
    .o_enable    (irq_enable),
    .o_irq       (irq_level)
  );

  assign alu.f        = i_file_rdata;
  assign alu.w        = core_reg.acc;
  assign alu.carry_in = core_reg.c;
  assign alu.op       = i_instr_op;

  assign accept    = i_instr_valid && (core_reg.phase == core_exec_pkg::PH_RUN);
  assign clear_we  = i_reg_we && (i_reg_addr == core_exec_pkg::REG_IRQ_CLEAR);
  assign enable_we = i_reg_we && (i_reg_addr == core_exec_pkg::REG_IRQ_ENABLE);

  always_comb begin
    state_word = '0;
    state_word[core_exec_pkg::ST_ACC_LSB +: core_exec_pkg::DATA_W] =
      core_reg.acc;
    state_word[core_exec_pkg::ST_CARRY]     = core_reg.c;
    state_word[core_exec_pkg::ST_DCARRY]    = core_reg.dc;
    state_word[core_exec_pkg::ST_ZERO]      = core_reg.z;
    state_word[core_exec_pkg::ST_TIMEOUT]   = core_reg.to;
    state_word[core_exec_pkg::ST_POWERDOWN] = core_reg.pd;
    state_word[core_exec_pkg::ST_SLEEPING]  =
      (core_reg.phase == core_exec_pkg::PH_SLEEP);
    state_word[core_exec_pkg::ST_FLUSHING]  =
      (core_reg.phase == core_exec_pkg::PH_FLUSH);
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    core_next           = core_reg;
    core_next.file_we   = 1'b0;
    core_next.stack_pop = 1'b0;
    core_next.wdt_clear = 1'b0;
    events              = '0;
    unique case (core_reg.phase)
      core_exec_pkg::PH_RUN: begin
        if (accept) begin
          core_next.pc = core_reg.pc + core_exec_pkg::PC_STEP;
          unique case (i_instr_op)
            core_exec_pkg::CONFIG_LOAD_OP: begin
              core_next.cfg = core_reg.acc;
            end
            core_exec_pkg::LOAD_LITERAL_OP: begin
              core_next.acc = i_instr_literal;
            end
            core_exec_pkg::RETURN_LITERAL_OP: begin
              core_next.acc       = i_instr_literal;
              core_next.pc        = i_stack_top;
              core_next.stack_pop = 1'b1;
              core_next.phase     = core_exec_pkg::PH_FLUSH;
              events[core_exec_pkg::EVT_RETURN] = 1'b1;
            end
            core_exec_pkg::SLEEP_OP: begin
              core_next.wdt_clear = 1'b1;
              core_next.to        = 1'b1;
              core_next.pd        = 1'b0;
              core_next.phase     = core_exec_pkg::PH_SLEEP;
              events[core_exec_pkg::EVT_SLEEP] = 1'b1;
            end
            core_exec_pkg::ROTATE_LEFT_OP,
            core_exec_pkg::SUBTRACT_OP: begin
              core_next.c = alu.carry_out;
              if (i_instr_op == core_exec_pkg::SUBTRACT_OP) begin
                core_next.dc = alu.dc_out;
                core_next.z  = alu.zero_out;
                events[core_exec_pkg::EVT_BORROW] = ~alu.carry_out;
              end
              if (i_instr_dest == core_exec_pkg::DEST_FILE) begin
                core_next.file_we    = 1'b1;
                core_next.file_addr  = i_instr_file_addr;
                core_next.file_wdata = alu.result;
              end else begin
                core_next.acc = alu.result;
              end
            end
            default: begin
              core_next.phase = core_exec_pkg::PH_RUN;
            end
          endcase
        end
      end
      core_exec_pkg::PH_FLUSH: begin
        // The instruction offered now was fetched behind the return.
        core_next.phase = core_exec_pkg::PH_RUN;
      end
      core_exec_pkg::PH_SLEEP: begin
        if (i_wake) begin
          core_next.phase = core_exec_pkg::PH_RUN;
        end
      end
      default: begin
        core_next.phase = core_exec_pkg::PH_RUN;
      end
    endcase
    core_next.ready = (core_next.phase == core_exec_pkg::PH_RUN);
    core_next.sleep = (core_next.phase == core_exec_pkg::PH_SLEEP);
    core_next.rdata = '0;
    if (i_reg_re) begin
      unique case (i_reg_addr)
        core_exec_pkg::REG_IRQ_STATUS: begin
          core_next.rdata = {{(core_exec_pkg::RDATA_W -
                               core_exec_pkg::EVT_W){1'b0}}, irq_status};
        end
        core_exec_pkg::REG_IRQ_ENABLE: begin
          core_next.rdata = {{(core_exec_pkg::RDATA_W -
                               core_exec_pkg::EVT_W){1'b0}}, irq_enable};
        end
        core_exec_pkg::REG_CORE_STATE: begin
          core_next.rdata = state_word;
        end
        default: begin
          core_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      core_reg            <= '0;
      core_reg.phase      <= core_exec_pkg::PH_RUN;
      core_reg.acc        <= core_exec_pkg::ACC_RST;
      core_reg.cfg        <= core_exec_pkg::CONFIG_RST;
      core_reg.pc         <= core_exec_pkg::PC_RST;
      core_reg.to         <= core_exec_pkg::TIMEOUT_RST;
      core_reg.pd         <= core_exec_pkg::POWERDOWN_RST;
      core_reg.ready      <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_ready            = core_reg.ready;
  assign o_file_we          = core_reg.file_we;
  assign o_file_addr        = core_reg.file_addr;
  assign o_file_wdata       = core_reg.file_wdata;
  assign o_stack_pop        = core_reg.stack_pop;
  assign o_program_counter  = core_reg.pc;
  assign o_prescaler_config = core_reg.cfg;
  assign o_watchdog_clear   = core_reg.wdt_clear;
  assign o_sleep            = core_reg.sleep;
  assign o_accumulator      = core_reg.acc;
  assign o_carry_flag       = core_reg.c;
  assign o_digit_carry_flag = core_reg.dc;
  assign o_zero_flag        = core_reg.z;
  assign o_timeout_flag     = core_reg.to;
  assign o_powerdown_flag   = core_reg.pd;
  assign o_reg_rdata        = core_reg.rdata;
  assign o_irq              = irq_level;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [core_exec_pkg::DATA_W-1:0] sub_ref;
  logic                             sub_no_borrow;
  logic                             sub_dc_ref;
  logic                             sub_zero;

  assign sub_ref       = i_file_rdata - core_reg.acc;
  assign sub_no_borrow = (i_file_rdata >= core_reg.acc);
  assign sub_dc_ref    = (i_file_rdata[3:0] >= core_reg.acc[3:0]);
  assign sub_zero      = (sub_ref == 8'h00);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence exec_op(logic [core_exec_pkg::OP_W-1:0] op);
    accept && (i_instr_op == op);
  endsequence

  sequence flush_then_run;
    (!o_ready && o_stack_pop) ##1 (o_ready && !o_stack_pop && !o_file_we);
  endsequence

  a_config_load: assert property (
    exec_op(core_exec_pkg::CONFIG_LOAD_OP) |=>
      o_prescaler_config == $past(o_accumulator) &&
      $stable(o_carry_flag) && $stable(o_zero_flag) &&
      $stable(o_digit_carry_flag))
    else $error("config load wrong");

  a_literal_load: assert property (
    exec_op(core_exec_pkg::LOAD_LITERAL_OP) |=>
      o_accumulator == $past(i_instr_literal) && $stable(o_zero_flag) &&
      $stable(o_carry_flag) && $stable(o_timeout_flag))
    else $error("literal load wrong");

  a_return_load: assert property (
    exec_op(core_exec_pkg::RETURN_LITERAL_OP) |=>
      o_accumulator == $past(i_instr_literal) &&
      o_program_counter == $past(i_stack_top) && o_stack_pop &&
      $stable(o_carry_flag))
    else $error("return load wrong");

  a_return_flush: assert property (
    exec_op(core_exec_pkg::RETURN_LITERAL_OP) |=>
      flush_then_run ##0 ($stable(o_accumulator) &&
      $stable(o_program_counter)))
    else $error("return did not drop next instruction");

  a_sleep_watchdog: assert property (
    exec_op(core_exec_pkg::SLEEP_OP) |=> o_watchdog_clear ##1
      !o_watchdog_clear)
    else $error("sleep did not clear watchdog");

  a_sleep_flags: assert property (
    exec_op(core_exec_pkg::SLEEP_OP) |=>
      o_timeout_flag && !o_powerdown_flag && o_sleep)
    else $error("sleep flags wrong");

  a_sleep_halt: assert property (
    o_sleep && !i_wake |=> o_sleep && !o_file_we &&
      $stable(o_accumulator) && $stable(o_program_counter))
    else $error("instruction ran during sleep");

  a_rotate_left: assert property (
    exec_op(core_exec_pkg::ROTATE_LEFT_OP) ##0
      (i_instr_dest == core_exec_pkg::DEST_ACC) |=>
      o_accumulator == {$past(i_file_rdata[6:0]), $past(o_carry_flag)} &&
      o_carry_flag == $past(i_file_rdata[7]) && $stable(o_zero_flag) &&
      $stable(o_digit_carry_flag))
    else $error("rotate left wrong");

  a_subtract_value: assert property (
    exec_op(core_exec_pkg::SUBTRACT_OP) ##0
      (i_instr_dest == core_exec_pkg::DEST_FILE) |=>
      o_file_we && o_file_wdata == $past(sub_ref) &&
      o_file_addr == $past(i_instr_file_addr))
    else $error("subtract result wrong");

  a_dest_acc: assert property (
    accept && i_instr_dest == core_exec_pkg::DEST_ACC &&
      (i_instr_op == core_exec_pkg::SUBTRACT_OP ||
       i_instr_op == core_exec_pkg::ROTATE_LEFT_OP) |=> !o_file_we)
    else $error("accumulator destination wrote file");

  a_subtract_borrow: assert property (
    exec_op(core_exec_pkg::SUBTRACT_OP) |=>
      o_carry_flag == $past(sub_no_borrow) &&
      o_digit_carry_flag == $past(sub_dc_ref))
    else $error("subtract borrow flags wrong");

  a_zero_flag: assert property (
    exec_op(core_exec_pkg::SUBTRACT_OP) |=>
      o_zero_flag == $past(sub_zero))
    else $error("zero flag wrong");

  a_zero_hold: assert property (
    accept && i_instr_op != core_exec_pkg::SUBTRACT_OP |=>
      $stable(o_zero_flag))
    else $error("zero flag moved without subtract");

endmodule
`default_nettype wire

// ---- verif/test_cpu_instruction_subset_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_cpu_instruction_subset_exec;
  typedef struct packed {
    logic [2:0] op;
    logic [4:0] fa;
    logic       d;
    logic [7:0] lit;
    logic [7:0] frd;
    logic [7:0] acc;
    logic [2:0] flags;
    logic       we;
    logic [7:0] wd;
    logic [7:0] cfg;
  } row_s;

  // Columns: op, file, dest, literal, file data, then the expected
  // accumulator, carry/digit carry/zero, write pulse, write data, config.
  row_s rows [0:8] = '{
    '{3'h2, 5'h00, 1'h0, 8'h00, 8'h00, 8'h00, 3'h0, 1'h0, 8'h00, 8'hff},
    '{3'h2, 5'h00, 1'h0, 8'h35, 8'h00, 8'h35, 3'h0, 1'h0, 8'h00, 8'hff},
    '{3'h6, 5'h03, 1'h1, 8'h00, 8'h35, 8'h35, 3'h7, 1'h1, 8'h00, 8'hff},
    '{3'h6, 5'h04, 1'h0, 8'h00, 8'h10, 8'hdb, 3'h0, 1'h0, 8'h00, 8'hff},
    '{3'h5, 5'h05, 1'h1, 8'h00, 8'h80, 8'hdb, 3'h4, 1'h1, 8'h00, 8'hff},
    '{3'h5, 5'h06, 1'h0, 8'h00, 8'h01, 8'h03, 3'h0, 1'h0, 8'h00, 8'hff},
    '{3'h2, 5'h00, 1'h0, 8'h5a, 8'h00, 8'h5a, 3'h0, 1'h0, 8'h00, 8'hff},
    '{3'h1, 5'h00, 1'h0, 8'h00, 8'h00, 8'h5a, 3'h0, 1'h0, 8'h00, 8'h5a},
    '{3'h7, 5'h00, 1'h0, 8'h00, 8'h00, 8'h5a, 3'h0, 1'h0, 8'h00, 8'h5a}
  };

  logic        i_clk, i_rst, i_instr_valid, i_instr_dest, i_wake;
  logic        i_reg_we, i_reg_re;
  logic [2:0]  i_instr_op;
  logic [4:0]  i_instr_file_addr;
  logic [7:0]  i_instr_literal, i_file_rdata;
  logic [9:0]  i_stack_top;
  logic [3:0]  i_reg_addr;
  logic [31:0] i_reg_wdata;
  logic        o_ready, o_file_we, o_stack_pop, o_watchdog_clear, o_sleep;
  logic        o_carry_flag, o_digit_carry_flag, o_zero_flag, o_irq;
  logic        o_timeout_flag, o_powerdown_flag;
  logic [4:0]  o_file_addr;
  logic [7:0]  o_file_wdata, o_prescaler_config, o_accumulator;
  logic [9:0]  o_program_counter;
  logic [31:0] o_reg_rdata;
  int          n_fail;
  int          checks;
  row_s        r;

  cpu_instruction_subset_exec dut (.i_clk, .i_rst, .i_instr_valid,
    .i_instr_op, .i_instr_file_addr, .i_instr_dest, .i_instr_literal,
    .o_ready, .i_file_rdata, .o_file_we, .o_file_addr, .o_file_wdata,
    .i_stack_top, .o_stack_pop, .o_program_counter, .o_prescaler_config,
    .o_watchdog_clear, .o_sleep, .i_wake, .o_accumulator, .o_carry_flag,
    .o_digit_carry_flag, .o_zero_flag, .o_timeout_flag, .o_powerdown_flag,
    .i_reg_addr, .i_reg_wdata, .i_reg_we, .i_reg_re, .o_reg_rdata, .o_irq);

  always #25 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_we    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_we    <= 1'b0;
  endtask

  // Read data is looked at in the one cycle after the strobe.
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_reg_re   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_re   <= 1'b0;
    #1;
    chk(o_reg_rdata, exp);
  endtask

  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_clk, i_instr_valid, i_instr_dest, i_wake, i_reg_we, i_reg_re} = 6'h0;
    {i_instr_op, i_instr_file_addr, i_instr_literal} = 16'h0;
    {i_file_rdata, i_stack_top, i_reg_addr, i_reg_wdata} = 54'h0;
    i_rst = 1'b1;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      @(posedge i_clk);
      i_instr_valid     <= 1'b1;
      i_instr_op        <= r.op;
      i_instr_file_addr <= r.fa;
      i_instr_dest      <= r.d;
      i_instr_literal   <= r.lit;
      i_file_rdata      <= r.frd;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      #1;
      chk(32'(o_accumulator), 32'(r.acc));
      chk(32'({o_carry_flag, o_digit_carry_flag, o_zero_flag}),
          32'(r.flags));
      chk(32'(o_file_we), 32'(r.we));
      if (r.we)
        chk(32'({o_file_addr, o_file_wdata}), 32'({r.fa, r.wd}));
      chk(32'(o_prescaler_config), 32'(r.cfg));
      chk(32'(o_program_counter), 32'(i + 1));
    end
    // Return, with a literal-load offered in the flush cycle.
    @(posedge i_clk);
    i_stack_top     <= 10'h2a5;
    i_instr_valid   <= 1'b1;
    i_instr_op      <= 3'h3;
    i_instr_literal <= 8'h77;
    @(posedge i_clk);
    i_instr_op      <= 3'h2;
    i_instr_literal <= 8'h11;
    #1;
    chk(32'({o_accumulator, o_program_counter}), 32'h1dea5);
    chk(32'({o_stack_pop, o_ready}), 32'h2);
    @(posedge i_clk);
    i_instr_op <= 3'h4;
    #1;
    chk(32'({o_accumulator, o_program_counter}), 32'h1dea5);
    chk(32'({o_stack_pop, o_ready}), 32'h1);
    // Sleep taken here; a literal-load stays offered while asleep.
    @(posedge i_clk);
    i_instr_op      <= 3'h2;
    i_instr_literal <= 8'h22;
    #1;
    chk(32'(o_watchdog_clear), 32'h1);
    chk(32'({o_timeout_flag, o_powerdown_flag}), 32'h2);
    chk(32'({o_sleep, o_ready}), 32'h2);
    repeat (3) @(posedge i_clk);
    i_instr_valid <= 1'b0;
    i_wake        <= 1'b1;
    #1;
    chk(32'({o_watchdog_clear, o_sleep}), 32'h1);
    chk(32'({o_accumulator, o_program_counter}), 32'h1dea6);
    @(posedge i_clk);
    i_wake <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(32'({o_sleep, o_ready}), 32'h1);
    // Status, enable, clear, read-only and unmapped places.
    reg_read(core_exec_pkg::REG_IRQ_STATUS, 32'h7);
    reg_write(core_exec_pkg::REG_IRQ_STATUS, 32'h0);
    reg_write(core_exec_pkg::REG_IRQ_ENABLE, 32'h2);
    reg_read(core_exec_pkg::REG_IRQ_ENABLE, 32'h2);
    chk(32'(o_irq), 32'h1);
    reg_write(core_exec_pkg::REG_IRQ_CLEAR, 32'h2);
    reg_read(core_exec_pkg::REG_IRQ_STATUS, 32'h5);
    chk(32'(o_irq), 32'h0);
    reg_read(core_exec_pkg::REG_IRQ_CLEAR, 32'h0);
    reg_read(4'h2, 32'h0);
    reg_read(core_exec_pkg::REG_CORE_STATE, 32'h877);
    // Reset again in mid-run; every state returns to its reset value.
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk(32'(o_accumulator), 32'h0);
    chk(32'(o_prescaler_config), 32'hff);
    chk(32'({o_program_counter, o_timeout_flag, o_powerdown_flag}), 32'h3);
    chk(32'({o_ready, o_irq, o_sleep}), 32'h4);
    reg_read(core_exec_pkg::REG_IRQ_ENABLE, 32'h0);
    final_report();
  end

  // Whole run is well under 200 cycles; this bound cuts a hang short.
  initial begin
    repeat (2000) @(posedge i_clk);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
